// >>> logic/dac_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
module dac_i2c_slave #(
  parameter int unsigned DAC_WIDTH = dac_pkg::DAC_BITS,
  parameter logic [6:0]  ADDR_HI   = dac_pkg::ADDR_HI_DEFAULT
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_o,
  input  wire logic        address_bit_zero_i,
  output var  logic [9:0]  dac_code_o,
  output var  logic        buffer_en_o,
  output var  logic        string_en_o,
  output var  logic        term_1k_o,
  output var  logic        term_100k_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o
);

  if (DAC_WIDTH != 10) begin : g_bad_width
    $error("only a 10-bit code is served");
  end
  if (ADDR_HI[0] != 1'b0) begin : g_bad_addr
    $error("address bit zero comes from the pin");
  end

  // line synchronisers: first stage read only by the second
  logic [2:0] pin_raw;
  logic [2:0] pin_s;
  logic       scl_prev_q;
  logic       sda_prev_q;

  // scl is only ever sampled here, never driven
  assign pin_raw = {address_bit_zero_i, sda_i, scl_i};  // R8

  for (genvar gi = 0; gi < 3; gi++) begin : g_sync
    logic [1:0] sync_q;
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        // bus lines idle high so no false edge follows reset
        sync_q <= (gi == 2) ? 2'h0 : 2'h3;
      end else begin
        sync_q <= {sync_q[0], pin_raw[gi]};  // R27
      end
    end
    assign pin_s[gi] = sync_q[1];
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= pin_s[0];  // R27
      sda_prev_q <= pin_s[1];
    end
  end

  wire scl_s    = pin_s[0];
  wire sda_s    = pin_s[1];
  wire adr0_s   = pin_s[2];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire scl_held = scl_s & scl_prev_q;
  wire start_ev = scl_held & sda_prev_q & ~sda_s;  // R10 R11
  wire stop_raw = scl_held & ~sda_prev_q & sda_s;  // R10 R11

  // state and datapath registers
  dac_pkg::dac_state_type state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [3:0] cmd_q;
  logic [3:0] cmd_hi_q;
  logic       rd_dir_q;
  logic       rd_second_q;
  logic       sda_low_q;
  logic       start_pulse_q;
  logic [9:0] input_reg_q;
  logic [9:0] dac_reg_q;
  logic [1:0] pd_q;
  logic [7:0] count_q;
  logic       ctrl_en_q;
  logic       nxt_bit_q;

  // a stop in the same high pulse as a start is not legal and is ignored
  wire stop_ev = stop_raw & ~start_pulse_q;  // R13

  wire [6:0] my_addr    = {ADDR_HI[6:1], adr0_s};          // R20
  wire       addr_bit   = my_addr[3'd6 - bit_cnt_q];       // R18
  wire       last_bit   = (bit_cnt_q == 3'd7);
  wire [9:0] new_code   = {cmd_hi_q, shift_q[7:2]};        // R1
  wire [7:0] tx_first   = {2'h0, pd_q, dac_reg_q[9:6]};
  wire [7:0] tx_second  = {dac_reg_q[5:0], 2'h0};
  wire       is_load    = (cmd_q == dac_pkg::CMD_LOAD_BOTH) |
                          (cmd_q == dac_pkg::CMD_LOAD_INPUT) |
                          (cmd_q == dac_pkg::CMD_LOAD_SHIFT);
  wire       commit     = (state_q == dac_pkg::ST_DACK) & scl_fall;  // R24
  wire       powered    = (pd_q == dac_pkg::PD_UP);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      start_pulse_q <= 1'b0;
    end else if (start_ev) begin
      start_pulse_q <= 1'b1;
    end else if (scl_fall) begin
      start_pulse_q <= 1'b0;
    end
  end

  // serial protocol engine; every bus move except the release on disable rides on scl edges
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q     <= dac_pkg::ST_IDLE;
      bit_cnt_q   <= 3'h0;
      shift_q     <= 8'h00;
      cmd_q       <= 4'h0;
      cmd_hi_q    <= 4'h0;
      rd_dir_q    <= 1'b0;
      rd_second_q <= 1'b0;
      sda_low_q   <= 1'b0;
      nxt_bit_q   <= 1'b0;
    end else if (!ctrl_en_q || stop_ev) begin
      // mid-byte stop aborts the write before any commit
      state_q   <= dac_pkg::ST_IDLE;  // R12 R25
      sda_low_q <= 1'b0;
    end else if (start_ev) begin
      state_q   <= dac_pkg::ST_ADDR;  // R12 R14
      bit_cnt_q <= 3'h0;
      nxt_bit_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      case (state_q)
        dac_pkg::ST_IDLE: begin
          sda_low_q <= 1'b0;  // R12
        end
        dac_pkg::ST_ADDR: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'd1;
            nxt_bit_q <= last_bit;
            if (last_bit) begin
              rd_dir_q <= sda_s;  // R18
            end else if (sda_s != addr_bit) begin
              state_q <= dac_pkg::ST_IDLE;  // R19 R12
            end
          end else if (scl_fall && nxt_bit_q) begin
            // the start pulse's own fall must not look like a finished byte
            nxt_bit_q <= 1'b0;
            state_q   <= dac_pkg::ST_AACK;
            sda_low_q <= 1'b1;  // R15 R21
          end
        end
        dac_pkg::ST_AACK: begin
          if (scl_fall) begin
            rd_second_q <= 1'b0;
            if (rd_dir_q) begin
              state_q   <= dac_pkg::ST_TX;
              shift_q   <= {tx_first[6:0], 1'b0};
              sda_low_q <= ~tx_first[7];  // R26 R9
              bit_cnt_q <= 3'h1;
            end else begin
              state_q   <= dac_pkg::ST_CMD;
              sda_low_q <= 1'b0;
            end
          end
        end
        dac_pkg::ST_CMD, dac_pkg::ST_DATA: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};  // R9
            bit_cnt_q <= bit_cnt_q + 3'd1;
            nxt_bit_q <= last_bit;
          end else if (scl_fall && nxt_bit_q) begin
            nxt_bit_q <= 1'b0;
            sda_low_q <= 1'b1;  // R15
            if (state_q == dac_pkg::ST_CMD) begin
              state_q  <= dac_pkg::ST_CACK;
              cmd_q    <= shift_q[7:4];  // R23
              cmd_hi_q <= shift_q[3:0];
            end else begin
              state_q <= dac_pkg::ST_DACK;
            end
          end
        end
        dac_pkg::ST_CACK: begin
          if (scl_fall) begin
            state_q   <= dac_pkg::ST_DATA;
            sda_low_q <= 1'b0;
          end
        end
        dac_pkg::ST_DACK: begin
          if (scl_fall) begin
            state_q   <= dac_pkg::ST_CMD;  // R14
            sda_low_q <= 1'b0;
          end
        end
        dac_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == 3'd0) begin
              state_q   <= dac_pkg::ST_TXACK;
              sda_low_q <= 1'b0;  // R16 R21
            end else begin
              sda_low_q <= ~shift_q[7];  // R9
              shift_q   <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 3'd1;
            end
          end
        end
        dac_pkg::ST_TXACK: begin
          if (scl_rise) begin
            nxt_bit_q <= ~sda_s & ~rd_second_q;  // R16 R17
          end else if (scl_fall) begin
            if (nxt_bit_q) begin
              state_q     <= dac_pkg::ST_TX;  // R26
              rd_second_q <= 1'b1;
              shift_q     <= {tx_second[6:0], 1'b0};
              sda_low_q   <= ~tx_second[7];
              bit_cnt_q   <= 3'h1;
            end else begin
              state_q <= dac_pkg::ST_IDLE;
            end
            nxt_bit_q <= 1'b0;
          end
        end
        default: begin
          state_q <= dac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // register file; both registers survive powerdown untouched
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      input_reg_q <= dac_pkg::CODE_RESET;  // R2
      dac_reg_q   <= dac_pkg::CODE_RESET;  // R2
      pd_q        <= dac_pkg::PD_RESET;    // R2 R3
      count_q     <= 8'h00;
    end else if (commit) begin
      count_q <= count_q + 8'd1;
      if (is_load) begin
        input_reg_q <= new_code;  // R7
      end
      if (cmd_q == dac_pkg::CMD_LOAD_BOTH) begin
        dac_reg_q <= new_code;  // R7
      end else if (cmd_q == dac_pkg::CMD_LOAD_SHIFT || cmd_q == dac_pkg::CMD_UPDATE) begin
        dac_reg_q <= input_reg_q;  // R23
      end
      if (cmd_q[3:2] == dac_pkg::CMD_PD_HI) begin
        pd_q <= cmd_hi_q[3:2];  // R23 R4 R6
      end
    end
  end

  // analog control outputs
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dac_code_o  <= dac_pkg::CODE_RESET;
      buffer_en_o <= 1'b0;
      string_en_o <= 1'b0;
      term_1k_o   <= 1'b0;
      term_100k_o <= 1'b1;
      sda_o       <= 1'b0;
      sda_oe_o    <= 1'b0;
    end else begin
      dac_code_o  <= dac_reg_q;  // R6
      buffer_en_o <= powered;    // R5
      string_en_o <= powered;    // R5
      term_1k_o   <= (pd_q == dac_pkg::PD_1K);    // R4
      term_100k_o <= (pd_q == dac_pkg::PD_100K);  // R4
      sda_o       <= 1'b0;       // R21
      sda_oe_o    <= sda_low_q;  // R21
    end
  end

  // wishbone slave: one wait state, ack drops after one cycle
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        hit_ctrl = (wb_adr_i == dac_pkg::OFS_CTRL);
  wire        hit_stat = (wb_adr_i == dac_pkg::OFS_STATUS);
  wire        hit_in   = (wb_adr_i == dac_pkg::OFS_INPUT);
  wire        hit_dac  = (wb_adr_i == dac_pkg::OFS_DAC);
  wire        hit_cnt  = (wb_adr_i == dac_pkg::OFS_COUNT);
  wire        active   = (state_q != dac_pkg::ST_IDLE);
  logic [31:0] stat_w;
  wire [31:0] rd_mux;

  // field positions shared with software through the package
  always_comb begin
    stat_w = 32'h0;
    stat_w[dac_pkg::ST_PD_LSB +: 2]  = pd_q;
    stat_w[dac_pkg::ST_ACTIVE_BIT]   = active;
    stat_w[dac_pkg::ST_ADDR0_BIT]    = adr0_s;
    stat_w[dac_pkg::ST_CMD_LSB +: 4] = cmd_q;
  end

  assign rd_mux = hit_ctrl ? {31'h0, ctrl_en_q} :
                  hit_stat ? stat_w :
                  hit_in   ? {22'h0, input_reg_q} :
                  hit_dac  ? {22'h0, dac_reg_q} :
                  hit_cnt  ? {24'h0, count_q} : 32'h0;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0;
      ctrl_en_q <= dac_pkg::CTRL_EN_RESET;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0;
      // disabling mid-transfer drops the slave off the bus at once
      if (wb_req && wb_we_i && hit_ctrl && wb_sel_i[0]) begin
        ctrl_en_q <= wb_dat_i[dac_pkg::CTRL_EN_BIT];
      end
    end
  end

endmodule : dac_i2c_slave
`default_nettype wire

// >>> shared/dac_pkg.sv
// Behaviour
// R1 - dac code is unsigned 10-bit binary
// R2 - reset clears registers, selects 100k powerdown
// R3 - master must send wake-up before conversions
// R4 - powerdown bits: 00 up, 01/10/11 modes
// R5 - any powerdown disables buffer and string
// R6 - registers kept through powerdown, restored on wake
// R7 - write dac directly or input register only
// R8 - slave only; master clocks at most 400 kHz
// R9 - bytes are 8 bits msb first plus ack
// R10 - data changes while clock high are control events
// R11 - start is sda fall, stop sda rise, scl high
// R12 - after stop or mismatch ignore until start
// R13 - stop honoured anywhere except start's high pulse
// R14 - back-to-back writes; reads need repeated start
// R15 - ack matching address and data bytes low
// R16 - release sda at ninth clock when transmitting
// R17 - master ends with nack then stop
// R18 - first byte: 7-bit address then direction bit
// R19 - compare address bitwise, drop out on mismatch
// R20 - address bits 6..1 fixed, bit 0 from pin
// R21 - bus lines driven open-drain only
// R22 - master retries later on missing ack
// R23 - command field decode for loads, read, powerdown; read code not decoded, reads go by direction bit
// R24 - commit on falling scl ending data ack
// R25 - aborted write leaves registers unchanged
// R26 - read returns dac register as two bytes
// R27 - both lines synchronised, one common view
package dac_pkg;

  localparam int unsigned DAC_BITS = 10;

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INPUT  = 8'h08;
  localparam logic [7:0] OFS_DAC    = 8'h0C;
  localparam logic [7:0] OFS_COUNT  = 8'h10;

  // control fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam logic        CTRL_EN_RESET  = 1'b1;

  // status field positions
  localparam int unsigned ST_PD_LSB      = 0;
  localparam int unsigned ST_ACTIVE_BIT  = 2;
  localparam int unsigned ST_ADDR0_BIT   = 3;
  localparam int unsigned ST_CMD_LSB     = 4;

  // powerdown select encodings
  localparam logic [1:0] PD_UP    = 2'h0;
  localparam logic [1:0] PD_FLOAT = 2'h1;
  localparam logic [1:0] PD_1K    = 2'h2;
  localparam logic [1:0] PD_100K  = 2'h3;
  localparam logic [1:0] PD_RESET = PD_100K;

  localparam logic [9:0] CODE_RESET = 10'h000;

  // command field encodings
  localparam logic [3:0] CMD_LOAD_BOTH  = 4'hC;
  localparam logic [3:0] CMD_LOAD_INPUT = 4'hD;
  localparam logic [3:0] CMD_LOAD_SHIFT = 4'hE;
  localparam logic [3:0] CMD_UPDATE     = 4'hF;
  localparam logic [1:0] CMD_READ_HI    = 2'h2;
  localparam logic [1:0] CMD_PD_HI      = 2'h1;

  localparam logic [6:0] ADDR_HI_DEFAULT = 7'h08;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_CMD   = 9'h008,
    ST_CACK  = 9'h010,
    ST_DATA  = 9'h020,
    ST_DACK  = 9'h040,
    ST_TX    = 9'h080,
    ST_TXACK = 9'h100
  } dac_state_type;

endpackage : dac_pkg

// >>> sim/dac_i2c_slave_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dac_i2c_slave_asserts (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic [9:0]  dac_code_o,
  input wire logic        buffer_en_o,
  input wire logic        string_en_o,
  input wire logic        term_1k_o,
  input wire logic        term_100k_o,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_reset_state: assert property (disable iff (1'b0) reset_i |=> dac_code_o == 10'h000 && term_100k_o
    && !term_1k_o && !buffer_en_o && !sda_oe_o) else $error("reset state wrong");
  a_open_drain: assert property (sda_o == 1'b0) else $error("sda driven high");
  a_pd_pair: assert property (buffer_en_o == string_en_o) else $error("buffer and string differ");
  a_term_excl: assert property (!(term_1k_o && term_100k_o)) else $error("two terminations");
  a_term_off_up: assert property (buffer_en_o |-> !term_1k_o && !term_100k_o) else $error("term while up");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data not zero");
  // sda may only move while the wire clock is low, else it reads as start or stop
  a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("sda moved, scl high");
  a_commit_ack: assert property ($changed(dac_code_o) |-> $past(sda_oe_o, 2) || $past(sda_oe_o, 3))
    else $error("code changed outside ack");
  c_ack: cover property ($rose(sda_oe_o));
  c_wake: cover property ($rose(buffer_en_o));
  c_term1k: cover property ($rose(term_1k_o));
endmodule : dac_i2c_slave_asserts
`default_nettype wire

// >>> sim/dac_i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dac_i2c_master_model (
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_oe_o
);
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  // data moves late in the low phase so the slave's ack release lands first
  task automatic put_bit(input logic b);
    #40 sda_oe_o = ~b;
    #10 scl_o = 1'b1;
    #30 scl_o = 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    #40 sda_oe_o = 1'b0;
    #10 scl_o = 1'b1;
    #20 b = sda_i;
    #10 scl_o = 1'b0;
  endtask : get_bit
  task automatic start_cond;
    #40 sda_oe_o = 1'b0;
    #10 scl_o = 1'b1;
    #15 sda_oe_o = 1'b1;
    #15 scl_o = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    #40 sda_oe_o = 1'b1;
    #10 scl_o = 1'b1;
    #15 sda_oe_o = 1'b0;
    #40;
  endtask : stop_cond
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
    ack = ~a;
  endtask : wr_byte
  task automatic rd_byte(output logic [7:0] v, input logic ack);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(~ack);
  endtask : rd_byte
endmodule : dac_i2c_master_model
`default_nettype wire

// >>> sim/dac_i2c_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dac_i2c_slave_tb;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        adr0    = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0;
  logic [3:0]  sel     = 4'hF;
  logic [31:0] rd, q;
  logic        scl, m_oe, s_oe, s_o, be, se, t1k, t100k, wack, k, k2;
  logic [9:0]  code;
  logic [7:0]  b1, b2;
  wire         sda = ~((s_oe & ~s_o) | m_oe); // pull-up when nobody pulls
  int          miscompares = 0;
  int          num_checks  = 0;
  // cmd, data, expected code, expected {buffer, string, 1k, 100k}
  logic [29:0] rows [10] = '{{8'hC0, 8'h00, 10'h000, 4'hC}, {8'hCF, 8'hFC, 10'h3FF, 4'hC},
    {8'hD5, 8'h54, 10'h3FF, 4'hC}, {8'hEA, 8'hA8, 10'h155, 4'hC}, {8'hF0, 8'h00, 10'h2AA, 4'hC},
    {8'h44, 8'h00, 10'h2AA, 4'h0}, {8'h48, 8'h00, 10'h2AA, 4'h2}, {8'h4C, 8'h00, 10'h2AA, 4'h1},
    {8'h40, 8'h00, 10'h2AA, 4'hC}, {8'hC0, 8'h00, 10'h000, 4'hC}};
  always #4 ref_clk = ~ref_clk;
  dac_i2c_slave dut (.ref_clk_i(ref_clk), .reset_i(reset), .scl_i(scl), .sda_i(sda), .sda_o(s_o),
    .sda_oe_o(s_oe), .address_bit_zero_i(adr0), .dac_code_o(code), .buffer_en_o(be), .string_en_o(se),
    .term_1k_o(t1k), .term_100k_o(t100k), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(wack));
  dac_i2c_master_model m (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask : cmp
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    @(posedge ref_clk);
    while (wack !== 1'b1) @(posedge ref_clk);
    q = rd;
    {cyc, stb, we} <= 3'b000;
    @(posedge ref_clk);
  endtask : wb
  task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, input logic e);
    logic k1, k3;
    m.start_cond();
    m.wr_byte(a, k1);
    m.wr_byte(c, k2);
    m.wr_byte(d, k3);
    m.stop_cond();
    cmp("ack", {31'h0, e}, {31'h0, k1 & k2 & k3});
    @(posedge ref_clk);
  endtask : xfer
  task automatic chk_out(input logic [9:0] c, input logic [3:0] o);
    cmp("code", {22'h0, c}, {22'h0, code});
    cmp("pd", {28'h0, o}, {28'h0, be, se, t1k, t100k});
  endtask : chk_out
  task automatic test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    #500000;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk_out(10'h000, 4'h1);
    m.start_cond(); // wake-up first
    m.wr_byte(8'h10, k);
    m.wr_byte(8'h40, k);
    m.wr_byte(8'h00, k);
    m.stop_cond();
    for (int i = 0; i < 10; i++) begin
      xfer(8'h10, rows[i][29:22], rows[i][21:14], 1'b1);
      chk_out(rows[i][13:4], rows[i][3:0]);
    end
    // two pairs with no stop, then a read after a repeated start
    m.start_cond();
    m.wr_byte(8'h10, k);
    m.wr_byte(8'hCF, k);
    m.wr_byte(8'hFC, k);
    m.wr_byte(8'hC8, k);
    m.wr_byte(8'h04, k);
    m.start_cond();
    m.wr_byte(8'h11, k);
    m.rd_byte(b1, 1'b1);
    m.rd_byte(b2, 1'b0);
    m.stop_cond();
    cmp("rd1", 32'h08, {24'h0, b1});
    cmp("rd2", 32'h04, {24'h0, b2});
    m.start_cond();
    m.wr_byte(8'h10, k);
    m.wr_byte(8'hCF, k);
    m.stop_cond();
    @(posedge ref_clk);
    cmp("abort", 32'h201, {22'h0, code});
    xfer(8'h12, 8'hC0, 8'h00, 1'b0);
    cmp("miss", 32'h201, {22'h0, code});
    adr0 <= 1'b1;
    xfer(8'h12, 8'hC0, 8'h00, 1'b1);
    chk_out(10'h000, 4'hC);
    adr0 <= 1'b0;
    wb(1'b1, 8'h0C, 32'h3FF);
    wb(1'b0, 8'h0C, 32'h0);
    cmp("dac reg", 32'h0, q);
    wb(1'b0, 8'h04, 32'h0);
    cmp("status", 32'hC0, q);
    wb(1'b0, 8'h20, 32'h0);
    cmp("unmapped", 32'h0, q);
    sel <= 4'hE;
    wb(1'b1, 8'h00, 32'h0);
    sel <= 4'hF;
    wb(1'b0, 8'h00, 32'h0);
    cmp("ctrl lane", 32'h1, q);
    wb(1'b1, 8'h00, 32'h0);
    xfer(8'h10, 8'hCF, 8'hFC, 1'b0); // disabled block answers nothing
    wb(1'b1, 8'h00, 32'h1);
    xfer(8'h10, 8'hCF, 8'hFC, 1'b1);
    chk_out(10'h3FF, 4'hC);
    wb(1'b0, 8'h08, 32'h0);
    cmp("input reg", 32'h3FF, q);
    wb(1'b0, 8'h10, 32'h0);
    cmp("count", 32'h0F, q);
    reset <= 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk_out(10'h000, 4'h1);
    wb(1'b0, 8'h08, 32'h0);
    cmp("input reset", 32'h0, q);
    wb(1'b0, 8'h10, 32'h0);
    cmp("count reset", 32'h0, q);
    test_done();
  end
endmodule : dac_i2c_slave_tb
bind dac_i2c_slave dac_i2c_slave_asserts u_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .dac_code_o(dac_code_o), .buffer_en_o(buffer_en_o),
  .string_en_o(string_en_o), .term_1k_o(term_1k_o), .term_100k_o(term_100k_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire
